// [dac_cmd_pkg.sv]
// Purpose: Shared constants and types for the reset and no-op command decoder
// Assumes: One 50 MHz clock; serial pins already synchronous to it
// Notes: Frame is 24 bits, most significant bit first
package dac_cmd_pkg;
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned DATA_BITS = 16;
    localparam int unsigned CNT_BITS = 5;
    localparam logic [4:0] FRAME_BITS_CNT = 5'h18;
    localparam logic [4:0] CNT_MAX = 5'h1F;

    localparam logic [3:0] ADDR_CTRL_WR = 4'h4;
    localparam logic [3:0] ADDR_DATA_RST = 4'h7;
    localparam logic [3:0] ADDR_FULL_RST = 4'hF;

    // Control-write field positions inside the 16-bit data
    localparam int unsigned RANGE_LSB = 0;
    localparam int unsigned RANGE_MSB = 2;
    localparam int unsigned RVS_LSB = 3;
    localparam int unsigned RVS_MSB = 4;

    localparam logic [1:0] RVS_ZERO = 2'h0;
    localparam logic [1:0] RVS_MID = 2'h1;
    localparam logic [1:0] RVS_FULL = 2'h2;

    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID = 16'h8000;
    localparam logic [15:0] CODE_FULL = 16'hFFFF;

    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [2:0] RANGE_RESET = 3'h0;
    localparam logic [1:0] RVS_RESET = 2'h0;

    typedef struct packed {
        logic [2:0] ignored;
        logic fixed_zero;
        logic [3:0] addr;
        logic [15:0] data;
    } frame_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DECODE = 2'b01,
        ST_APPLY = 2'b11
    } dec_state_type;

    function automatic logic [15:0] reset_code(input logic [1:0] sel);
        case (sel)
            RVS_MID: reset_code = CODE_MID;
            RVS_FULL: reset_code = CODE_FULL;
            default: reset_code = CODE_ZERO;
        endcase
    endfunction
endpackage

// [frame_shifter.sv]
// Purpose: Shifts in 24-bit command frames and flags complete ones
// Assumes: Serial clock, select and data sampled on mclk
// Notes: Bits taken on sampled rising edge of the serial clock
`timescale 1ns/10ps
module frame_shifter (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Serial pins
    input wire logic serial_clk,
    input wire logic frame_sel_b,
    input wire logic serial_data_input,
    // Frame out
    output dac_cmd_pkg::frame_type frame_ff,
    output logic frame_vld_ff
);
    logic sclk_q_ff;
    logic fsel_q_ff;
    logic [4:0] cnt_ff;
    logic [23:0] shreg_ff;
    logic bit_take;
    logic frame_end;

    assign bit_take = !frame_sel_b && serial_clk && !sclk_q_ff;
    assign frame_end = frame_sel_b && !fsel_q_ff;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q_ff <= 1'b0;
            fsel_q_ff <= 1'b1;
        end else begin
            sclk_q_ff <= serial_clk;
            fsel_q_ff <= frame_sel_b;
        end
    end

    // Count saturates so an overlong frame never wraps back to 24
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 5'h00;
            shreg_ff <= 24'h00_0000;
        end else if (frame_sel_b) begin
            cnt_ff <= 5'h00;
        end else if (bit_take) begin
            shreg_ff <= {shreg_ff[22:0], serial_data_input};
            if (cnt_ff != dac_cmd_pkg::CNT_MAX) begin
                cnt_ff <= cnt_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            frame_vld_ff <= 1'b0;
            frame_ff <= '0;
        end else begin
            frame_vld_ff <= frame_end && (cnt_ff == dac_cmd_pkg::FRAME_BITS_CNT);
            if (frame_end) begin
                frame_ff <= shreg_ff;
            end
        end
    end

    a_short_frame_drop: assert property (@(posedge mclk) disable iff (!rst_b)
        (frame_end && cnt_ff != dac_cmd_pkg::FRAME_BITS_CNT) |=> !frame_vld_ff)
        else $error("frame of wrong length accepted");
    a_full_frame_flag: assert property (@(posedge mclk) disable iff (!rst_b)
        (frame_end && cnt_ff == dac_cmd_pkg::FRAME_BITS_CNT) |=> frame_vld_ff)
        else $error("24-bit frame not flagged");
endmodule

// [dac_reset_nop_command_decoder.sv]
// Purpose: Executes data reset, full reset and no-op command frames
// Assumes: Host keeps bit 20 zero and reconfigures after full reset
// Notes: Control write stores range and reset value select
`timescale 1ns/10ps
module dac_reset_nop_command_decoder (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Serial interface
    input wire logic serial_clk,
    input wire logic frame_sel_b,
    input wire logic serial_data_input,
    // Output stage control
    output logic [15:0] dac_code_ff,
    output logic clamp_to_analog_ground_ff,
    output logic buffer_on_ff,
    output logic [2:0] range_ff,
    output logic [1:0] reset_value_select_ff,
    output logic cmd_done_ff
);
    dac_cmd_pkg::frame_type frame_in;
    dac_cmd_pkg::frame_type frame_q_ff;
    dac_cmd_pkg::dec_state_type state_ff;
    logic frame_vld;
    logic apply;
    logic do_ctrl;
    logic do_data_rst;
    logic do_full_rst;
    logic range_change;
    logic [2:0] new_range;
    logic [1:0] new_rvs;

    frame_shifter u_shift (
        .mclk(mclk),
        .rst_b(rst_b),
        .serial_clk(serial_clk),
        .frame_sel_b(frame_sel_b),
        .serial_data_input(serial_data_input),
        .frame_ff(frame_in),
        .frame_vld_ff(frame_vld)
    );

    // A frame with bit 20 set is malformed and dropped whole
    assign apply = (state_ff == dac_cmd_pkg::ST_APPLY) && !frame_q_ff.fixed_zero;
    assign do_ctrl = apply && (frame_q_ff.addr == dac_cmd_pkg::ADDR_CTRL_WR);
    assign do_data_rst = apply && (frame_q_ff.addr == dac_cmd_pkg::ADDR_DATA_RST);
    assign new_range = frame_q_ff.data[dac_cmd_pkg::RANGE_MSB:dac_cmd_pkg::RANGE_LSB];
    assign new_rvs = frame_q_ff.data[dac_cmd_pkg::RVS_MSB:dac_cmd_pkg::RVS_LSB];
    // Only counts as a change once the output is live
    assign range_change = do_ctrl && !clamp_to_analog_ground_ff && (new_range != range_ff);
    assign do_full_rst = (apply && frame_q_ff.addr == dac_cmd_pkg::ADDR_FULL_RST)
        || range_change;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= dac_cmd_pkg::ST_IDLE;
        end else begin
            case (state_ff)
                dac_cmd_pkg::ST_IDLE: if (frame_vld) state_ff <= dac_cmd_pkg::ST_DECODE;
                dac_cmd_pkg::ST_DECODE: state_ff <= dac_cmd_pkg::ST_APPLY;
                dac_cmd_pkg::ST_APPLY: state_ff <= dac_cmd_pkg::ST_IDLE;
                default: state_ff <= dac_cmd_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            frame_q_ff <= '0;
            cmd_done_ff <= 1'b0;
        end else begin
            if (frame_vld && state_ff == dac_cmd_pkg::ST_IDLE) begin
                frame_q_ff <= frame_in;
            end
            cmd_done_ff <= (state_ff == dac_cmd_pkg::ST_APPLY);
        end
    end

    // Data register: data bits of reset frames are never looked at
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dac_code_ff <= dac_cmd_pkg::CODE_RESET;
        end else if (do_full_rst) begin
            dac_code_ff <= dac_cmd_pkg::CODE_RESET;
        end else if (do_data_rst) begin
            dac_code_ff <= dac_cmd_pkg::reset_code(reset_value_select_ff);
        end
    end

    // Output stage: a plain control write releases clamp and powers buffer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clamp_to_analog_ground_ff <= 1'b1;
            buffer_on_ff <= 1'b0;
        end else if (do_full_rst) begin
            clamp_to_analog_ground_ff <= 1'b1;
            buffer_on_ff <= 1'b0;
        end else if (do_ctrl) begin
            clamp_to_analog_ground_ff <= 1'b0;
            buffer_on_ff <= 1'b1;
        end
    end

    // Configuration; a range change keeps the new setting through its reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            range_ff <= dac_cmd_pkg::RANGE_RESET;
            reset_value_select_ff <= dac_cmd_pkg::RVS_RESET;
        end else if (do_ctrl) begin
            range_ff <= new_range;
            reset_value_select_ff <= new_rvs;
        end else if (do_full_rst) begin
            range_ff <= dac_cmd_pkg::RANGE_RESET;
            reset_value_select_ff <= dac_cmd_pkg::RVS_RESET;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // No-op address table, one compare per entry
    localparam int unsigned NOP_COUNT = 5;
    localparam logic [19:0] NOP_ADDRS = 20'hE_D650;
    logic [NOP_COUNT-1:0] nop_hit;
    logic is_nop;

    for (genvar g = 0; g < NOP_COUNT; g++) begin : g_nop
        assign nop_hit[g] = (frame_q_ff.addr == NOP_ADDRS[g*4 +: 4]);
    end
    // Other unknown addresses belong to other command blocks
    assign is_nop = |nop_hit;

    // Cycles since the last executed frame, saturating so it never wraps
    // Read by the spacing check only; it never reaches an output
    logic [2:0] since_done_ff;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            since_done_ff <= 3'h7;
        end else if (cmd_done_ff) begin
            since_done_ff <= 3'h0;
        end else if (since_done_ff != 3'h7) begin
            since_done_ff <= since_done_ff + 3'h1;
        end
    end

    // Command effects
    a_data_reset_load: assert property ((state_ff == dac_cmd_pkg::ST_APPLY
        && !frame_q_ff.fixed_zero && frame_q_ff.addr == dac_cmd_pkg::ADDR_DATA_RST)
        |=> dac_code_ff == dac_cmd_pkg::reset_code($past(reset_value_select_ff)))
        else $error("data reset loaded wrong code");
    a_rvs_stored: assert property (do_ctrl |=> reset_value_select_ff
        == $past(frame_q_ff.data[dac_cmd_pkg::RVS_MSB:dac_cmd_pkg::RVS_LSB]))
        else $error("reset value select not stored");
    a_full_reset_state: assert property ((state_ff == dac_cmd_pkg::ST_APPLY
        && !frame_q_ff.fixed_zero && frame_q_ff.addr == dac_cmd_pkg::ADDR_FULL_RST)
        |=> dac_code_ff == dac_cmd_pkg::CODE_RESET && range_ff == dac_cmd_pkg::RANGE_RESET)
        else $error("full reset left state behind");
    a_full_reset_clamp: assert property (do_full_rst
        |=> clamp_to_analog_ground_ff && !buffer_on_ff)
        else $error("output not clamped after full reset");
    a_range_change_reset: assert property ((do_ctrl && !clamp_to_analog_ground_ff
        && new_range != range_ff) |=> clamp_to_analog_ground_ff [*1] ##0 !buffer_on_ff)
        else $error("range change did not reset");
    a_nop_holds: assert property ((state_ff == dac_cmd_pkg::ST_APPLY && is_nop)
        |=> $stable(dac_code_ff) && $stable(clamp_to_analog_ground_ff)
        && $stable(buffer_on_ff) && $stable(range_ff) && $stable(reset_value_select_ff))
        else $error("no-op frame changed state");
    a_frame_to_done: assert property ((frame_vld && state_ff == dac_cmd_pkg::ST_IDLE)
        |-> ##3 cmd_done_ff)
        else $error("frame not executed in three cycles");
    a_bad_bit_drop: assert property ((state_ff == dac_cmd_pkg::ST_APPLY
        && frame_q_ff.fixed_zero) |=> $stable(dac_code_ff) && $stable(buffer_on_ff))
        else $error("frame with bit 20 set executed");

    // Outputs other than cmd_done_ff move only in an apply cycle, and only the ones the command names
    a_quiet_off_apply: assert property ((state_ff != dac_cmd_pkg::ST_APPLY)
        |=> $stable(dac_code_ff) && $stable(clamp_to_analog_ground_ff)
        && $stable(buffer_on_ff) && $stable(range_ff) && $stable(reset_value_select_ff))
        else $error("output state changed outside an apply cycle");
    a_data_reset_only: assert property (do_data_rst
        |=> $stable(clamp_to_analog_ground_ff) && $stable(buffer_on_ff)
        && $stable(range_ff) && $stable(reset_value_select_ff))
        else $error("data reset touched more than the code");
    a_full_reset_select: assert property ((state_ff == dac_cmd_pkg::ST_APPLY
        && !frame_q_ff.fixed_zero && frame_q_ff.addr == dac_cmd_pkg::ADDR_FULL_RST)
        |=> reset_value_select_ff == dac_cmd_pkg::RVS_RESET)
        else $error("full reset kept the reset value select");
    a_range_stored: assert property (do_ctrl
        |=> range_ff == $past(frame_q_ff.data[dac_cmd_pkg::RANGE_MSB:dac_cmd_pkg::RANGE_LSB]))
        else $error("range setting not stored");
    a_ctrl_release: assert property ((do_ctrl && !range_change)
        |=> !clamp_to_analog_ground_ff && buffer_on_ff)
        else $error("control write did not release the output");

    // Output stage only ever sits clamped and off, or released and on
    a_clamp_buffer_pair: assert property (clamp_to_analog_ground_ff != buffer_on_ff)
        else $error("clamp and buffer out of step");
    a_code_legal: assert property (dac_code_ff == dac_cmd_pkg::CODE_ZERO
        || dac_code_ff == dac_cmd_pkg::CODE_MID || dac_code_ff == dac_cmd_pkg::CODE_FULL)
        else $error("code outside zero, mid and full scale");

    // Decode path: capture, decode, apply, done
    // A frame landing while busy is dropped, so done pulses keep their spacing
    a_decode_to_apply: assert property ((state_ff == dac_cmd_pkg::ST_DECODE)
        |=> state_ff == dac_cmd_pkg::ST_APPLY)
        else $error("decode did not lead to apply");
    a_frame_capture: assert property ((frame_vld && state_ff == dac_cmd_pkg::ST_IDLE)
        |=> frame_q_ff == $past(frame_in))
        else $error("frame not captured whole");
    a_done_from_apply: assert property (cmd_done_ff |-> $past(state_ff) == dac_cmd_pkg::ST_APPLY)
        else $error("done without an apply cycle");
    a_done_single: assert property (cmd_done_ff |=> !cmd_done_ff)
        else $error("done held longer than one cycle");
    a_done_spacing: assert property (cmd_done_ff |-> since_done_ff >= 3'h2)
        else $error("executed frames closer than the decode path allows");

    // Main scenarios
    c_data_reset: cover property (do_data_rst);
    c_full_reset: cover property (do_full_rst && !range_change);
    c_range_change: cover property (range_change);
    c_release: cover property (do_ctrl ##1 !clamp_to_analog_ground_ff);
    c_bad_bit: cover property (state_ff == dac_cmd_pkg::ST_APPLY && frame_q_ff.fixed_zero);
endmodule

// [host_model.sv]
// Purpose: Host model that shifts command frames into the decoder
// Assumes: Pins change just after rising mclk edges only
// Notes: Data line shows the inverse of its last bit while deselected
`timescale 1ns/10ps
module host_model (
    // Clock
    input wire logic mclk,
    // Serial pins
    output logic serial_clk,
    output logic frame_sel_b,
    output logic serial_data_input
);
    initial begin
        serial_clk = 1'b0;
        frame_sel_b = 1'b1;
        serial_data_input = 1'b0;
    end

    // Top nbits of word go out; slow stretches each serial clock phase
    task automatic send(input logic [31:0] word, input int nbits, input int slow);
        int i;
        @(posedge mclk);
        frame_sel_b <= 1'b0;
        for (i = 0; i < nbits; i++) begin
            serial_data_input <= word[31-i];
            repeat (2 + slow) @(posedge mclk);
            serial_clk <= 1'b1;
            repeat (2 + slow) @(posedge mclk);
            serial_clk <= 1'b0;
        end
        repeat (2) @(posedge mclk);
        frame_sel_b <= 1'b1;
        // No pull on the line, so never leave a stale bit behind
        serial_data_input <= ~serial_data_input;
    endtask
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the reset and no-op command decoder
// Assumes: Host model owns the serial pins
// Notes: Expected output state is tracked frame by frame
`timescale 1ns/10ps
module testbench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    wire serial_clk, frame_sel_b, serial_data_input;
    wire [15:0] dac_code_ff;
    wire clamp_to_analog_ground_ff, buffer_on_ff, cmd_done_ff;
    wire [2:0] range_ff;
    wire [1:0] reset_value_select_ff;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 32'h2b00_a798;
    int i;
    logic [15:0] e_code = 16'h0000;
    logic e_clamp = 1'b1;
    logic e_buf = 1'b0;
    logic [2:0] e_range = 3'h0;
    logic [1:0] e_sel = 2'h0;
    logic [1:0] sels [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
    logic [3:0] noops [5] = '{4'h0, 4'h5, 4'h6, 4'hd, 4'he};

    always #10 mclk = ~mclk;

    host_model host (.mclk(mclk), .serial_clk(serial_clk), .frame_sel_b(frame_sel_b),
        .serial_data_input(serial_data_input));
    dac_reset_nop_command_decoder uut (.mclk(mclk), .rst_b(rst_b), .serial_clk(serial_clk),
        .frame_sel_b(frame_sel_b), .serial_data_input(serial_data_input),
        .dac_code_ff(dac_code_ff), .clamp_to_analog_ground_ff(clamp_to_analog_ground_ff),
        .buffer_on_ff(buffer_on_ff), .range_ff(range_ff),
        .reset_value_select_ff(reset_value_select_ff), .cmd_done_ff(cmd_done_ff));

    function automatic logic [15:0] code_for(input logic [1:0] s);
        return (s == 2'h1) ? 16'h8000 : (s == 2'h2) ? 16'hffff : 16'h0000;
    endfunction

    function automatic logic [23:0] frm(input logic [3:0] a, input logic [15:0] d);
        return {3'($random(seed)), 1'b0, a, d};
    endfunction

    task automatic compare(input logic seen, input logic exp_seen);
        logic [23:0] got;
        logic [23:0] exp;
        got = {seen, dac_code_ff, clamp_to_analog_ground_ff, buffer_on_ff, range_ff,
            reset_value_select_ff};
        exp = {exp_seen, e_code, e_clamp, e_buf, e_range, e_sel};
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic model(input logic [23:0] f, input int nbits);
        if (nbits != 24 || f[20]) return;
        case (f[19:16])
            4'h4: begin
                if (!e_clamp && f[2:0] != e_range) begin
                    e_clamp = 1'b1;
                    e_buf = 1'b0;
                    e_code = 16'h0000;
                end else begin
                    e_clamp = 1'b0;
                    e_buf = 1'b1;
                end
                e_range = f[2:0];
                e_sel = f[4:3];
            end
            4'h7: e_code = code_for(e_sel);
            4'hf: begin
                e_code = 16'h0000;
                e_clamp = 1'b1;
                e_buf = 1'b0;
                e_range = 3'h0;
                e_sel = 2'h0;
            end
            default: ;
        endcase
    endtask

    task automatic run(input logic [23:0] f, input int nbits);
        logic seen;
        int k;
        seen = 1'b0;
        host.send({f, 8'h00}, nbits, $random(seed) & 1);
        for (k = 0; k < 10; k++) begin
            @(posedge mclk);
            #1;
            if (cmd_done_ff === 1'b1) seen = 1'b1;
        end
        model(f, nbits);
        compare(seen, nbits == 24);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #800000;
        n_errors++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        compare(1'b0, 1'b0);
        run(frm(4'h4, 16'h0002), 24);
        for (i = 0; i < 4; i++) begin
            run(frm(4'h4, {11'h000, sels[i], 3'h2}), 24);
            run(frm(4'h7, 16'($random(seed))), 24);
        end
        for (i = 0; i < 5; i++) run(frm(noops[i], 16'($random(seed))), 24);
        run(frm(4'hf, 16'h0000), 23);
        run(frm(4'hf, 16'h0000), 25);
        run({4'h1, 4'hf, 16'h0000}, 24);
        run(frm(4'h4, 16'h0015), 24);
        run(frm(4'h4, 16'h0015), 24);
        run(frm(4'h7, 16'h1234), 24);
        run(frm(4'hf, 16'($random(seed))), 24);
        for (i = 0; i < 30; i++) run(frm(4'($random(seed)), 16'($random(seed))), 24);
        test_done();
    end
endmodule
